// File: deep_sleep_params.svh
`ifndef DEEP_SLEEP_PARAMS_SVH
`define DEEP_SLEEP_PARAMS_SVH

// ********************************
// Register offsets
// ********************************
`define DSG_OFS_SOFT_RESET     12'h040
`define DSG_OFS_DEEP_GATE      12'h128
`define DSG_OFS_GATE_STATUS    12'h200

// ********************************
// Field positions and widths
// ********************************
`define DSG_PORT_COUNT         8
`define DSG_BIT_FIELD_BUS      24
`define DSG_BIT_ADC            16
`define DSG_BIT_HIBERNATION    6
`define DSG_BIT_WATCHDOG       3
`define DSG_SRST_WRITABLE      32'h0101_0048
`define DSG_STAT_STATE_LSB     8
`define DSG_STAT_AUTO_BIT      10

// ********************************
// Reset values and answers
// ********************************
`define DSG_RST_DEEP_GATE      8'h00
`define DSG_RST_SOFT_RESET     32'h0000_0000
`define DSG_RESP_OKAY          2'h0
`define DSG_RESP_SLVERR        2'h2

`endif

// File: sysctl_pkg.sv
package sysctl_pkg;

	// System power state as seen by the gating select
	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_SLEEP,
		PWR_DEEP
	} power_state_e;

	// Register selected by an address
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_SOFT_RESET,
		SEL_DEEP_GATE,
		SEL_GATE_STATUS
	} reg_sel_e;

	// Reset lines to the controlled units, active high
	typedef struct packed {
		logic field_bus_ctrl_reset;
		logic adc_reset;
		logic hibernation_reset;
		logic watchdog_reset;
	} unit_reset_s;

endpackage

// File: deep_sleep_gating_and_soft_reset.sv
`timescale 1ns/1ns
`include "deep_sleep_params.svh"


module deep_sleep_gating_and_soft_reset #(
	parameter int ADDR_W = 12
) (
	input  wire logic                           mclk,        // System clock
	input  wire logic                           nrst,        // Async reset
	input  wire logic [ADDR_W-1:0]              s_axi_awaddr,  // Write addr
	input  wire logic                           s_axi_awvalid, // Addr valid
	output logic                                s_axi_awready, // Addr ready
	input  wire logic [31:0]                    s_axi_wdata,   // Write data
	input  wire logic [3:0]                     s_axi_wstrb,   // Byte lanes
	input  wire logic                           s_axi_wvalid,  // Data valid
	output logic                                s_axi_wready,  // Data ready
	output logic [1:0]                          s_axi_bresp,   // Write resp
	output logic                                s_axi_bvalid,  // Resp valid
	input  wire logic                           s_axi_bready,  // Resp ready
	input  wire logic [ADDR_W-1:0]              s_axi_araddr,  // Read addr
	input  wire logic                           s_axi_arvalid, // Addr valid
	output logic                                s_axi_arready, // Addr ready
	output logic [31:0]                         s_axi_rdata,   // Read data
	output logic [1:0]                          s_axi_rresp,   // Read resp
	output logic                                s_axi_rvalid,  // Data valid
	input  wire logic                           s_axi_rready,  // Data ready
	input  wire sysctl_pkg::power_state_e       power_state,   // Power mode
	input  wire logic                           auto_gating_select, // Auto
	input  wire logic [`DSG_PORT_COUNT-1:0]     run_port_clock_gate,   // Run
	input  wire logic [`DSG_PORT_COUNT-1:0]     sleep_port_clock_gate, // Slp
	input  wire logic [31:0]                    capability_mask_1, // Present
	input  wire logic [`DSG_PORT_COUNT-1:0]     port_access,   // Port access
	output logic [`DSG_PORT_COUNT-1:0]          port_clk_en,   // Port clock en
	output logic                                port_bus_fault, // Fault pulse
	output sysctl_pkg::unit_reset_s             unit_reset     // Unit resets
);

	// ********************************
	// Address decode
	// ********************************
	function automatic sysctl_pkg::reg_sel_e decode(
		input logic [ADDR_W-1:0] addr
	);
		decode = sysctl_pkg::SEL_NONE;
		if (addr == ADDR_W'(`DSG_OFS_SOFT_RESET))
			decode = sysctl_pkg::SEL_SOFT_RESET;
		else if (addr == ADDR_W'(`DSG_OFS_DEEP_GATE))
			decode = sysctl_pkg::SEL_DEEP_GATE;
		else if (addr == ADDR_W'(`DSG_OFS_GATE_STATUS))
			decode = sysctl_pkg::SEL_GATE_STATUS;
	endfunction

	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	logic                         aw_held;
	logic                         w_held;
	logic [ADDR_W-1:0]            aw_addr;
	logic [31:0]                  w_data;
	logic [3:0]                   w_strb;
	logic                         do_write;
	sysctl_pkg::reg_sel_e         wsel;
	sysctl_pkg::reg_sel_e         rsel;
	logic [31:0]                  wmask;
	logic [31:0]                  srst_mask;
	logic [`DSG_PORT_COUNT-1:0]   deep_gate;
	logic [31:0]                  soft_reset;
	logic [31:0]                  next_soft_reset;
	logic [`DSG_PORT_COUNT-1:0]   next_deep_gate;

	// ********************************
	// Write channel
	// ********************************
	// Address and data are taken in either order, one write at a time
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;
	assign wsel          = decode(aw_addr);
	assign wmask         = lane_mask(w_strb);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `DSG_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wsel == sysctl_pkg::SEL_NONE) ?
				`DSG_RESP_SLVERR : `DSG_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ********************************
	// Registers
	// ********************************
	// capability masked write
	assign srst_mask = wmask & `DSG_SRST_WRITABLE & capability_mask_1;
	assign next_soft_reset = (soft_reset & ~srst_mask) | (w_data & srst_mask);
	assign next_deep_gate = (deep_gate & ~wmask[`DSG_PORT_COUNT-1:0]) |
		(w_data[`DSG_PORT_COUNT-1:0] & wmask[`DSG_PORT_COUNT-1:0]);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			deep_gate <= `DSG_RST_DEEP_GATE;
		else if (do_write && wsel == sysctl_pkg::SEL_DEEP_GATE)
			deep_gate <= next_deep_gate;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			soft_reset <= `DSG_RST_SOFT_RESET;
		else if (do_write && wsel == sysctl_pkg::SEL_SOFT_RESET)
			soft_reset <= next_soft_reset;
	end

	always_comb begin
		unit_reset.field_bus_ctrl_reset = soft_reset[`DSG_BIT_FIELD_BUS];
		unit_reset.adc_reset            = soft_reset[`DSG_BIT_ADC];
		unit_reset.hibernation_reset    = soft_reset[`DSG_BIT_HIBERNATION];
		unit_reset.watchdog_reset       = soft_reset[`DSG_BIT_WATCHDOG];
	end

	// ********************************
	// Clock gate select
	// ********************************
	// enable clocks the port
	always_comb begin
		if (!auto_gating_select) begin
			port_clk_en = run_port_clock_gate;
		end else begin
			unique case (power_state)
				sysctl_pkg::PWR_RUN:   port_clk_en = run_port_clock_gate;
				sysctl_pkg::PWR_SLEEP: port_clk_en = sleep_port_clock_gate;
				sysctl_pkg::PWR_DEEP:  port_clk_en = deep_gate;
				default:               port_clk_en = run_port_clock_gate;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			port_bus_fault <= 1'b0;
		else
			port_bus_fault <= |(port_access & ~port_clk_en);
	end

	// ********************************
	// Read channel
	// ********************************
	assign s_axi_arready = !s_axi_rvalid;
	assign rsel          = decode(s_axi_araddr);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `DSG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `DSG_RESP_OKAY;
			s_axi_rdata  <= '0;
			unique case (rsel)
				sysctl_pkg::SEL_SOFT_RESET:
					s_axi_rdata <= soft_reset;
				sysctl_pkg::SEL_DEEP_GATE:
					s_axi_rdata[`DSG_PORT_COUNT-1:0] <= deep_gate;
				sysctl_pkg::SEL_GATE_STATUS: begin
					s_axi_rdata[`DSG_PORT_COUNT-1:0] <= port_clk_en;
					s_axi_rdata[`DSG_STAT_STATE_LSB +: 2] <= power_state;
					s_axi_rdata[`DSG_STAT_AUTO_BIT] <= auto_gating_select;
				end
				sysctl_pkg::SEL_NONE:
					s_axi_rresp <= `DSG_RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	logic seen_write;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			seen_write <= 1'b0;
		else if (do_write)
			seen_write <= 1'b1;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	AST_RESET_ZERO: assert property (
		!seen_write |-> deep_gate == '0)
		else $error("deep gate not zero before first write");

	AST_GATE_DEEP: assert property (
		auto_gating_select && power_state == sysctl_pkg::PWR_DEEP
		|-> port_clk_en == deep_gate)
		else $error("deep-sleep gate not applied");

	AST_GATE_SLEEP: assert property (
		auto_gating_select && power_state == sysctl_pkg::PWR_SLEEP
		|-> port_clk_en == sleep_port_clock_gate)
		else $error("sleep gate not applied");

	AST_NO_AUTO: assert property (
		!auto_gating_select |-> port_clk_en == run_port_clock_gate)
		else $error("sleep sets applied without auto gating");

	AST_FAULT: assert property (
		|(port_access & ~port_clk_en) |=> port_bus_fault)
		else $error("access to unclocked port not faulted");

	AST_NO_FAULT: assert property (
		!(|(port_access & ~port_clk_en)) |=> !port_bus_fault)
		else $error("fault without unclocked access");

	AST_SRST_MASK: assert property (
		do_write && wsel == sysctl_pkg::SEL_SOFT_RESET
		|=> ((soft_reset ^ $past(soft_reset)) &
			~$past(capability_mask_1)) == '0)
		else $error("soft reset bit changed without capability");

	AST_SRST_READ: assert property (
		s_axi_arvalid && s_axi_arready
		&& rsel == sysctl_pkg::SEL_SOFT_RESET
		|=> s_axi_rdata[`DSG_BIT_FIELD_BUS] ==
			$past(unit_reset.field_bus_ctrl_reset)
		&& s_axi_rdata[`DSG_BIT_ADC] == $past(unit_reset.adc_reset)
		&& s_axi_rdata[`DSG_BIT_HIBERNATION] ==
			$past(unit_reset.hibernation_reset)
		&& s_axi_rdata[`DSG_BIT_WATCHDOG] ==
			$past(unit_reset.watchdog_reset))
		else $error("soft reset readback differs from reset lines");

	AST_SRST_RSVD: assert property (
		(soft_reset & ~`DSG_SRST_WRITABLE) == '0)
		else $error("reserved soft reset bit set");

	AST_DEEP_READ: assert property (
		s_axi_arvalid && s_axi_arready
		&& rsel == sysctl_pkg::SEL_DEEP_GATE
		|=> s_axi_rvalid && s_axi_rdata[31:`DSG_PORT_COUNT] == '0
		&& s_axi_rdata[`DSG_PORT_COUNT-1:0] == $past(deep_gate))
		else $error("deep gate readback wrong");

	AST_HIB_WRITE: assert property (
		do_write && wsel == sysctl_pkg::SEL_SOFT_RESET
		&& w_strb[0] && capability_mask_1[`DSG_BIT_HIBERNATION]
		|=> unit_reset.hibernation_reset ==
			$past(w_data[`DSG_BIT_HIBERNATION]))
		else $error("hibernation reset did not follow write");

	AST_BRESP_UNMAPPED: assert property (
		do_write && wsel == sysctl_pkg::SEL_NONE
		|=> s_axi_bvalid && s_axi_bresp == `DSG_RESP_SLVERR)
		else $error("unmapped write not refused");

	COV_DEEP_FAULT: cover property (
		power_state == sysctl_pkg::PWR_DEEP && auto_gating_select
		&& port_access != '0 ##1 port_bus_fault);
	COV_SRST_PULSE: cover property (
		unit_reset.watchdog_reset ##[1:20] !unit_reset.watchdog_reset);
	COV_UNMAPPED_READ: cover property (
		s_axi_rvalid && s_axi_rresp == `DSG_RESP_SLVERR);
	COV_DEEP_WRITE: cover property (
		do_write && wsel == sysctl_pkg::SEL_DEEP_GATE);

endmodule

// File: test_deep_sleep_gating_and_soft_reset.sv
`timescale 1ns/1ns

module test_deep_sleep_gating_and_soft_reset;
	logic                     mclk = 1'b0;
	logic                     nrst = 1'b0;
	logic [11:0]              s_axi_awaddr = 12'h000;
	logic                     s_axi_awvalid = 1'b0;
	logic                     s_axi_awready;
	logic [31:0]              s_axi_wdata = 32'h0000_0000;
	logic [3:0]               s_axi_wstrb = 4'h0;
	logic                     s_axi_wvalid = 1'b0;
	logic                     s_axi_wready;
	logic [1:0]               s_axi_bresp;
	logic                     s_axi_bvalid;
	logic                     s_axi_bready = 1'b0;
	logic [11:0]              s_axi_araddr = 12'h000;
	logic                     s_axi_arvalid = 1'b0;
	logic                     s_axi_arready;
	logic [31:0]              s_axi_rdata;
	logic [1:0]               s_axi_rresp;
	logic                     s_axi_rvalid;
	logic                     s_axi_rready = 1'b0;
	sysctl_pkg::power_state_e power_state = sysctl_pkg::PWR_DEEP;
	logic                     auto_gating_select = 1'b1;
	logic [7:0]               run_port_clock_gate = 8'h3c;
	logic [7:0]               sleep_port_clock_gate = 8'hc3;
	logic [31:0]              capability_mask_1 = 32'hffff_ffff;
	logic [7:0]               port_access = 8'h00;
	logic [7:0]               port_clk_en;
	logic                     port_bus_fault;
	sysctl_pkg::unit_reset_s  unit_reset;
	int                       err_total = 0;
	int                       num_checks = 0;

	always #2 mclk = ~mclk;

	deep_sleep_gating_and_soft_reset DUT (
		.mclk                  (mclk),
		.nrst                  (nrst),
		.s_axi_awaddr          (s_axi_awaddr),
		.s_axi_awvalid         (s_axi_awvalid),
		.s_axi_awready         (s_axi_awready),
		.s_axi_wdata           (s_axi_wdata),
		.s_axi_wstrb           (s_axi_wstrb),
		.s_axi_wvalid          (s_axi_wvalid),
		.s_axi_wready          (s_axi_wready),
		.s_axi_bresp           (s_axi_bresp),
		.s_axi_bvalid          (s_axi_bvalid),
		.s_axi_bready          (s_axi_bready),
		.s_axi_araddr          (s_axi_araddr),
		.s_axi_arvalid         (s_axi_arvalid),
		.s_axi_arready         (s_axi_arready),
		.s_axi_rdata           (s_axi_rdata),
		.s_axi_rresp           (s_axi_rresp),
		.s_axi_rvalid          (s_axi_rvalid),
		.s_axi_rready          (s_axi_rready),
		.power_state           (power_state),
		.auto_gating_select    (auto_gating_select),
		.run_port_clock_gate   (run_port_clock_gate),
		.sleep_port_clock_gate (sleep_port_clock_gate),
		.capability_mask_1     (capability_mask_1),
		.port_access           (port_access),
		.port_clk_en           (port_clk_en),
		.port_bus_fault        (port_bus_fault),
		.unit_reset            (unit_reset)
	);

	// ********************************
	// Shared tasks
	// ********************************
	task automatic stop_test;
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Waits are open; only the watchdog ends one that never answers
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int  n;
		bit  aw_d;
		bit  w_d;
		n = 0;
		aw_d = 1'b0;
		w_d = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_d && w_d)) begin
			@(posedge mclk);
			n++;
			if (!aw_d && s_axi_awready === 1'b1) begin
				aw_d = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_d && s_axi_wready === 1'b1) begin
				w_d = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) begin
			@(posedge mclk);
			n++;
		end
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
		// Idle slave: take at edge 1, answer seen at edge 3
		chk(32'(n), 32'h0000_0003);
	endtask

	task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge mclk);
			n++;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk(32'(s_axi_rresp), 32'(er));
		// Data stands from the edge after the address is taken
		chk(32'(n), 32'h0000_0002);
	endtask

	task automatic mode(input sysctl_pkg::power_state_e ps, input logic au,
		input logic [7:0] exp);
		@(posedge mclk);
		power_state <= ps;
		auto_gating_select <= au;
		@(negedge mclk);
		chk(32'(port_clk_en), 32'(exp));
	endtask

	task automatic srst(input logic [31:0] cap, input logic [31:0] d,
		input logic [31:0] er, input logic [3:0] eu);
		capability_mask_1 <= cap;
		axi_wr(12'h040, d, 4'hf, 2'h0);
		axi_rd(12'h040, er, 2'h0);
		chk(32'(unit_reset), 32'(eu));
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_reset;
		@(negedge mclk);
		chk(32'(port_clk_en), 32'h0000_0000);
		chk(32'(unit_reset), 32'h0000_0000);
		axi_rd(12'h128, 32'h0000_0000, 2'h0);
		axi_rd(12'h040, 32'h0000_0000, 2'h0);
	endtask

	task automatic t_deep_reg;
		axi_wr(12'h128, 32'hffff_ffa5, 4'hf, 2'h0);
		axi_rd(12'h128, 32'h0000_00a5, 2'h0);
		// Byte lane 0 not strobed: gate bits keep their value
		axi_wr(12'h128, 32'h0000_00ff, 4'he, 2'h0);
		axi_rd(12'h128, 32'h0000_00a5, 2'h0);
	endtask

	task automatic t_select;
		mode(sysctl_pkg::PWR_DEEP, 1'b1, 8'ha5);
		axi_rd(12'h200, 32'h0000_06a5, 2'h0);
		mode(sysctl_pkg::PWR_SLEEP, 1'b1, 8'hc3);
		mode(sysctl_pkg::PWR_RUN, 1'b1, 8'h3c);
		mode(sysctl_pkg::PWR_DEEP, 1'b0, 8'h3c);
		mode(sysctl_pkg::PWR_SLEEP, 1'b0, 8'h3c);
		mode(sysctl_pkg::PWR_DEEP, 1'b1, 8'ha5);
	endtask

	task automatic t_fault;
		@(posedge mclk);
		port_access <= 8'h02;
		@(posedge mclk);
		port_access <= 8'h01;
		@(negedge mclk);
		chk(32'(port_bus_fault), 32'h0000_0001);
		@(posedge mclk);
		port_access <= 8'h00;
		@(negedge mclk);
		chk(32'(port_bus_fault), 32'h0000_0000);
	endtask

	task automatic t_soft_reset;
		srst(32'h0000_0040, 32'hffff_ffff, 32'h0000_0040, 4'h2);
		srst(32'hffff_ffff, 32'hffff_ffff, 32'h0101_0048, 4'hf);
		srst(32'h0100_0008, 32'h0000_0000, 32'h0001_0040, 4'h6);
		srst(32'hffff_ffff, 32'h0000_0000, 32'h0000_0000, 4'h0);
	endtask

	task automatic t_unmapped;
		axi_wr(12'h124, 32'h0000_00ff, 4'hf, 2'h2);
		axi_rd(12'h124, 32'h0000_0000, 2'h2);
		// Status word is read-only: write accepted, nothing changes
		axi_wr(12'h200, 32'h0000_0000, 4'hf, 2'h0);
		axi_rd(12'h128, 32'h0000_00a5, 2'h0);
	endtask

	initial begin
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		t_reset();
		t_deep_reg();
		t_select();
		t_fault();
		t_soft_reset();
		t_unmapped();
		stop_test();
	end

	// Whole run needs under a hundred cycles
	initial begin
		#20000;
		err_total++;
		stop_test();
	end
endmodule
